// ==== verilog/rpm_pkg.sv ====
// Package with constants and types for the reader power mode control.
// Operation
// - Pins plus four mode bits choose seven states.
// - Activate pin enables regulators, oscillator, clock output.
// - Wake pin alone keeps auxiliary rail, 60 kHz.
// - Wake rising edge starts supplies like activate.
// - No activate within 100 us: back down.
// - Settled supplies switch clock output to crystal.
// - Low-power hold: low-power regulators, 100 us recovery.
// - All mode bits clear: RF off, 25 us.
// - Receive bit alone runs only the receiver.
// - Transmit bit runs both; half-power bit halves.
// - Swap bit exchanges the two RF inputs.
// - Tag response stores both signal strengths.
// - Protocol write loads receiver filter presets.
// - Transmission clears strength; reception latches peak.
`default_nettype none

package rpm_pkg;

  // Register bus geometry.
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [4:0] OFS_CHIP_CTRL = 5'h00;
  localparam logic [4:0] OFS_PROTOCOL  = 5'h01;
  localparam logic [4:0] OFS_RX_SPEC   = 5'h0a;
  localparam logic [4:0] OFS_RSSI      = 5'h0f;

  // Field positions in the chip power and mode control register.
  localparam int unsigned BIT_HOLD  = 7;
  localparam int unsigned BIT_TX    = 5;
  localparam int unsigned BIT_HALF  = 4;
  localparam int unsigned BIT_SWAP  = 3;
  localparam int unsigned BIT_RX    = 1;

  // Values after reset.
  localparam logic [7:0] CHIP_CTRL_RST = 8'h00;
  localparam logic [7:0] PROTOCOL_RST  = 8'h00;

  // Filter presets, one per protocol group (protocol bits 4:3).
  localparam logic [7:0] RX_PRESET0 = 8'h40;
  localparam logic [7:0] RX_PRESET1 = 8'h10;
  localparam logic [7:0] RX_PRESET2 = 8'h20;
  localparam logic [7:0] RX_PRESET3 = 8'h00;

  // Timing, figures in their own units and derived cycle counts.
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned AUX_CLK_HZ    = 60_000;
  localparam int unsigned WAKE_TMO_US   = 100;
  localparam int unsigned HOLD_RCV_US   = 100;
  localparam int unsigned IDLE_RCV_US   = 25;
  localparam int unsigned AUX_HALF_CYC  = CLK_HZ / (2 * AUX_CLK_HZ);
  localparam int unsigned WAKE_TMO_CYC  = WAKE_TMO_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HOLD_RCV_CYC  = HOLD_RCV_US * (CLK_HZ / 1_000_000);
  localparam int unsigned IDLE_RCV_CYC  = IDLE_RCV_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TMR_W         = 12;

  // Power state codes seen by software and by the analog side.
  typedef enum logic [2:0] {
    RPM_MODE_OFF     = 3'h0,
    RPM_MODE_PARTIAL = 3'h1,
    RPM_MODE_HOLD    = 3'h2,
    RPM_MODE_IDLE    = 3'h3,
    RPM_MODE_RXONLY  = 3'h4,
    RPM_MODE_TXHALF  = 3'h5,
    RPM_MODE_TXFULL  = 3'h6
  } rpm_mode_t;

  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_OFF     = 6'h01,
    ST_AUX     = 6'h02,
    ST_START   = 6'h04,
    ST_WAKE    = 6'h08,
    ST_CONFIRM = 6'h10,
    ST_ACTIVE  = 6'h20
  } rpm_state_t;

  // Controls toward the analog front end.
  typedef struct packed {
    logic reg_en;
    logic reg_lowpwr;
    logic osc_en;
    logic aux_rail_en;
    logic clk_out_en;
    logic clk_sel_xtal;
    logic rx_en;
    logic tx_en;
    logic tx_half;
    logic input_swap;
  } rpm_pwr_ctl_t;

  // Signal-strength levels of both receivers.
  typedef struct packed {
    logic [2:0] aux;
    logic [2:0] main;
  } rpm_rssi_t;

endpackage : rpm_pkg

`default_nettype wire

// ==== verilog/rpm_timer.sv ====
// Loadable down counter used for timeouts and recovery delays.
`default_nettype none

module rpm_timer #(
  parameter int unsigned W = 12
) (
  input  wire logic         core_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         stop_i,
  output logic              busy_o,
  output logic              done_o
);

  logic [W-1:0] cnt_q;   // Cycles left.
  logic         busy_q;  // Counting.

  // Load wins over stop so a restart is never lost.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (load_i) begin
      cnt_q  <= load_val_i;
      busy_q <= 1'b1;
    end else if (stop_i) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 1'b1;
      // Stop after the last count so done is one cycle long.
      if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign busy_o = busy_q;
  // Pulse in the cycle the count reaches its end.
  assign done_o = busy_q && !load_i && !stop_i
                  && (cnt_q == {{(W-1){1'b0}}, 1'b1});

endmodule : rpm_timer

`default_nettype wire

// ==== verilog/rpm_power_ctrl.sv ====
// Power-mode sequencer and mode registers of the reader front end.
//
// The plain strobed port was decided locally.
`default_nettype none

module rpm_power_ctrl (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  // Register port.
  input  wire logic [4:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [7:0]                 reg_rdata_o,
  // Enable pins.
  input  wire logic                  reader_en_i,
  input  wire logic                  wake_pin_i,
  // Analog status.
  input  wire logic                  settle_done_i,
  input  wire logic                  reader_tx_start_i,
  input  wire logic                  tag_resp_i,
  input  wire logic                  rx_busy_i,
  input  wire logic [2:0]            first_rf_input_lvl_i,
  input  wire logic [2:0]            second_rf_input_lvl_i,
  // Controls and status.
  output rpm_pkg::rpm_pwr_ctl_t      pwr_ctl_o,
  output rpm_pkg::rpm_mode_t         pwr_mode_o,
  output logic                       aux_clk_o,
  output logic                       full_ready_o,
  output logic [7:0]                 rx_filter_o
);
  import rpm_pkg::*;

  rpm_state_t   state_q;       // Sequencer state.
  rpm_state_t   state_d;       // Next sequencer state.
  logic [7:0]   chip_ctrl_q;   // Chip power and mode control.
  logic [7:0]   protocol_q;    // Protocol selection.
  logic [7:0]   rx_spec_q;     // Receiver special settings.
  rpm_rssi_t    rssi_q;        // Latched peak strengths.
  logic         wake_q;        // Wake pin one cycle ago.
  logic         wake_rise;     // Rising edge of the wake pin.
  logic [8:0]   aux_div_q;     // Auxiliary clock divider.
  logic         aux_clk_q;     // Auxiliary clock level.
  rpm_mode_t    mode_d;        // Decoded power mode.
  rpm_mode_t    mode_q;        // Registered power mode.
  rpm_pwr_ctl_t ctl_d;         // Next analog controls.
  rpm_pwr_ctl_t ctl_q;         // Registered analog controls.
  logic         tmo_load;      // Start confirmation timeout.
  logic         tmo_done;      // Confirmation timeout expired.
  logic         rcv_load;      // Start a recovery delay.
  logic [TMR_W-1:0] rcv_val;   // Length of that delay.
  logic         rcv_busy;      // Recovery still running.
  logic [7:0]   rdata_q;       // Read data register.

  // Larger of two strength codes, used for both receivers.
  function automatic logic [2:0] peak3(input logic [2:0] a,
                                       input logic [2:0] b);
    peak3 = (a > b) ? a : b;
  endfunction : peak3

  // Filter preset for a protocol selection.
  function automatic logic [7:0] preset_for(input logic [7:0] proto);
    case (proto[4:3])
      2'h0:    preset_for = RX_PRESET0;
      2'h1:    preset_for = RX_PRESET1;
      2'h2:    preset_for = RX_PRESET2;
      default: preset_for = RX_PRESET3;
    endcase
  endfunction : preset_for

  // Wake pin history; the pin is synchronous so one flop suffices.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_pin_i;
    end
  end

  assign wake_rise = wake_pin_i && !wake_q;

  // Sequencer next state.
  always_comb begin
    state_d  = state_q;
    tmo_load = 1'b0;
    case (state_q)
      ST_OFF: begin
        if (reader_en_i) begin
          state_d = ST_START;
        end else if (wake_rise) begin
          state_d = ST_WAKE;
        end else if (wake_pin_i) begin
          // A held pin with no edge only gives the partial mode.
          state_d = ST_AUX;
        end
      end
      ST_AUX: begin
        if (reader_en_i) begin
          state_d = ST_START;
        end else if (!wake_pin_i) begin
          state_d = ST_OFF;
        end
      end
      ST_START: begin
        if (!reader_en_i) begin
          state_d = wake_pin_i ? ST_AUX : ST_OFF;
        end else if (settle_done_i) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_WAKE: begin
        if (reader_en_i) begin
          state_d = ST_START;
        end else if (settle_done_i) begin
          // Clock switches now, so the timeout starts here.
          state_d  = ST_CONFIRM;
          tmo_load = 1'b1;
        end
      end
      ST_CONFIRM: begin
        if (reader_en_i) begin
          state_d = ST_ACTIVE;
        end else if (tmo_done) begin
          state_d = ST_OFF;
        end
      end
      ST_ACTIVE: begin
        if (!reader_en_i) begin
          state_d = wake_pin_i ? ST_AUX : ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Confirmation timeout after a wake-pin start.
  rpm_timer #(
    .W (TMR_W)
  ) u_wake_tmo (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .load_i     (tmo_load),
    .load_val_i (TMR_W'(WAKE_TMO_CYC)),
    .stop_i     (state_q != ST_CONFIRM),
    .busy_o     (),
    .done_o     (tmo_done)
  );

  // Mode decode; the hold bit masks the transmit and receive bits.
  always_comb begin
    case (state_q)
      ST_OFF:  mode_d = RPM_MODE_OFF;
      ST_AUX:  mode_d = RPM_MODE_PARTIAL;
      ST_ACTIVE: begin
        if (chip_ctrl_q[BIT_HOLD]) begin
          mode_d = RPM_MODE_HOLD;
        end else if (chip_ctrl_q[BIT_TX]) begin
          mode_d = chip_ctrl_q[BIT_HALF] ? RPM_MODE_TXHALF
                                         : RPM_MODE_TXFULL;
        end else if (chip_ctrl_q[BIT_RX]) begin
          mode_d = RPM_MODE_RXONLY;
        end else begin
          mode_d = RPM_MODE_IDLE;
        end
      end
      // Start-up phases run as in the idle mode.
      default: mode_d = RPM_MODE_IDLE;
    endcase
  end

  // Analog controls derived from state and mode.
  always_comb begin
    ctl_d              = '0;
    ctl_d.aux_rail_en  = (state_q != ST_OFF);
    ctl_d.clk_out_en   = (state_q != ST_OFF);
    ctl_d.reg_en       = (state_q != ST_OFF) && (state_q != ST_AUX);
    ctl_d.osc_en       = ctl_d.reg_en;
    ctl_d.clk_sel_xtal = (state_q == ST_CONFIRM)
                         || (state_q == ST_ACTIVE);
    ctl_d.reg_lowpwr   = (mode_d == RPM_MODE_HOLD);
    ctl_d.rx_en        = (mode_d == RPM_MODE_RXONLY)
                         || (mode_d == RPM_MODE_TXHALF)
                         || (mode_d == RPM_MODE_TXFULL);
    ctl_d.tx_en        = (mode_d == RPM_MODE_TXHALF)
                         || (mode_d == RPM_MODE_TXFULL);
    ctl_d.tx_half      = (mode_d == RPM_MODE_TXHALF);
    ctl_d.input_swap   = chip_ctrl_q[BIT_SWAP];
  end

  // Controls and mode are registered so the pins never glitch.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ctl_q  <= '0;
      mode_q <= RPM_MODE_OFF;
    end else begin
      ctl_q  <= ctl_d;
      mode_q <= mode_d;
    end
  end

  // Recovery delay when leaving hold, or leaving idle for a mode other than hold.
  always_comb begin
    rcv_load = 1'b0;
    rcv_val  = TMR_W'(IDLE_RCV_CYC);
    if (mode_q == RPM_MODE_HOLD && mode_d != RPM_MODE_HOLD
        && state_q == ST_ACTIVE) begin
      rcv_load = 1'b1;
      rcv_val  = TMR_W'(HOLD_RCV_CYC);
    end else if (mode_q == RPM_MODE_IDLE && mode_d != RPM_MODE_IDLE
                 && mode_d != RPM_MODE_HOLD && state_q == ST_ACTIVE) begin
      rcv_load = 1'b1;
    end
  end

  rpm_timer #(
    .W (TMR_W)
  ) u_recover (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .load_i     (rcv_load),
    .load_val_i (rcv_val),
    .stop_i     (state_q != ST_ACTIVE),
    .busy_o     (rcv_busy),
    .done_o     ()
  );

  // Ready once active and no recovery delay is pending.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      full_ready_o <= 1'b0;
    end else begin
      full_ready_o <= (state_q == ST_ACTIVE) && !rcv_busy && !rcv_load;
    end
  end

  // Auxiliary clock divider; it runs only while the clock is enabled.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !ctl_q.clk_out_en) begin
      aux_div_q <= '0;
      aux_clk_q <= 1'b0;
    end else if (aux_div_q == 9'(AUX_HALF_CYC - 1)) begin
      aux_div_q <= '0;
      aux_clk_q <= !aux_clk_q;
    end else begin
      aux_div_q <= aux_div_q + 9'h001;
    end
  end

  // Chip control register; new bits steer the decode next clock.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      chip_ctrl_q <= CHIP_CTRL_RST;
    end else if (reg_wr_i && reg_addr_i == OFS_CHIP_CTRL) begin
      // Written bits are not gated by the clock switch; software waits.
      chip_ctrl_q <= reg_wdata_i;
    end
  end

  // Protocol register; each write reloads the filter presets.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      protocol_q <= PROTOCOL_RST;
    end else if (reg_wr_i && reg_addr_i == OFS_PROTOCOL) begin
      protocol_q <= reg_wdata_i;
    end
  end

  // Receiver settings: preset on protocol write, refinable after.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_spec_q <= preset_for(PROTOCOL_RST);
    end else if (reg_wr_i && reg_addr_i == OFS_PROTOCOL) begin
      rx_spec_q <= preset_for(reg_wdata_i);
    end else if (reg_wr_i && reg_addr_i == OFS_RX_SPEC) begin
      rx_spec_q <= reg_wdata_i;
    end
  end

  assign rx_filter_o = rx_spec_q;

  // Strength latch: cleared at each transmission, peak kept otherwise.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || reader_tx_start_i) begin
      rssi_q <= '0;
    end else if (tag_resp_i && rx_busy_i) begin
      // Swap decides which input feeds which receiver.
      if (ctl_q.input_swap) begin
        rssi_q.main <= peak3(rssi_q.main, second_rf_input_lvl_i);
        rssi_q.aux  <= peak3(rssi_q.aux, first_rf_input_lvl_i);
      end else begin
        rssi_q.main <= peak3(rssi_q.main, first_rf_input_lvl_i);
        rssi_q.aux  <= peak3(rssi_q.aux, second_rf_input_lvl_i);
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_CHIP_CTRL: rdata_q <= chip_ctrl_q;
        OFS_PROTOCOL:  rdata_q <= protocol_q;
        OFS_RX_SPEC:   rdata_q <= rx_spec_q;
        OFS_RSSI:      rdata_q <= {1'b0, ctl_q.clk_sel_xtal,
                                   rssi_q.aux, rssi_q.main};
        default:       rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign pwr_ctl_o   = ctl_q;
  assign pwr_mode_o  = mode_q;
  assign aux_clk_o   = aux_clk_q;

endmodule : rpm_power_ctrl

`default_nettype wire

// ==== verif/rpm_power_ctrl_props.sv ====
// Checker of the reader power mode sequencer, seen from its ports.
`default_nettype none

module rpm_power_ctrl_props (
  input wire logic               core_clk_i,
  input wire logic               reset_n_i,
  input wire logic [4:0]         reg_addr_i,
  input wire logic [7:0]         reg_wdata_i,
  input wire logic               reg_wr_i,
  input wire logic               reader_en_i,
  input wire logic               settle_done_i,
  input wire rpm_pkg::rpm_pwr_ctl_t pwr_ctl_o,
  input wire rpm_pkg::rpm_mode_t pwr_mode_o,
  input wire logic               full_ready_o
);
  import rpm_pkg::*;

  // One clock domain, so clock and reset are stated once for all.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  logic mode_wr;  // Mode write while fully running.
  logic swap_w;   // Swap bit of the written data.
  assign mode_wr = reg_wr_i && (reg_addr_i == OFS_CHIP_CTRL) && full_ready_o;
  assign swap_w  = reg_wdata_i[BIT_SWAP];

  // Long waits are counted, not written as delay ranges.
  logic [12:0] tmo_c, hold_c, idle_c; // Cycles waited.
  rpm_mode_t   mode_p;                // Last mode.
  always_ff @(posedge core_clk_i) begin
    mode_p <= pwr_mode_o;
    tmo_c  <= (pwr_ctl_o.clk_sel_xtal && !reader_en_i) ? tmo_c + 13'h1 : '0;
    hold_c <= !full_ready_o && reader_en_i && (hold_c != '0 ||
      (mode_p == RPM_MODE_HOLD && pwr_mode_o != RPM_MODE_HOLD))
      ? hold_c + 13'h1 : '0;
    idle_c <= !full_ready_o && reader_en_i && (idle_c != '0 ||
      (mode_p == RPM_MODE_IDLE && pwr_mode_o > RPM_MODE_IDLE))
      ? idle_c + 13'h1 : '0;
  end

  property p_hold_wr;
    mode_wr && reg_wdata_i[BIT_HOLD] ##1 reader_en_i |=>
      pwr_mode_o == RPM_MODE_HOLD;
  endproperty
  a_hold_wr: assert property (p_hold_wr)
    else $error("hold write not applied on time");
  property p_swap;
    mode_wr ##1 reader_en_i |=> pwr_ctl_o.input_swap == $past(swap_w, 2);
  endproperty
  a_swap: assert property (p_swap)
    else $error("input swap does not follow the written bit");
  property p_tx;
    pwr_mode_o inside {RPM_MODE_TXHALF, RPM_MODE_TXFULL} |->
      pwr_ctl_o.tx_en && pwr_ctl_o.rx_en &&
      (pwr_ctl_o.tx_half == (pwr_mode_o == RPM_MODE_TXHALF));
  endproperty
  a_tx: assert property (p_tx)
    else $error("transmit mode controls wrong");
  property p_rxonly;
    pwr_mode_o == RPM_MODE_RXONLY |-> pwr_ctl_o.rx_en && !pwr_ctl_o.tx_en;
  endproperty
  a_rxonly: assert property (p_rxonly)
    else $error("receive-only mode controls wrong");
  property p_hold;
    pwr_mode_o == RPM_MODE_HOLD |-> pwr_ctl_o.reg_lowpwr &&
      pwr_ctl_o.osc_en && pwr_ctl_o.clk_out_en && !pwr_ctl_o.tx_en;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold mode controls wrong");
  property p_partial;
    pwr_mode_o == RPM_MODE_PARTIAL |-> pwr_ctl_o.aux_rail_en &&
      pwr_ctl_o.clk_out_en && !pwr_ctl_o.clk_sel_xtal && !pwr_ctl_o.osc_en;
  endproperty
  a_partial: assert property (p_partial)
    else $error("partial mode controls wrong");
  property p_en_on;
    $rose(reader_en_i) ##1 reader_en_i |=> pwr_ctl_o.reg_en &&
      pwr_ctl_o.osc_en && pwr_ctl_o.clk_out_en;
  endproperty
  a_en_on: assert property (p_en_on)
    else $error("activate pin did not start supplies");
  property p_settle;
    reader_en_i && settle_done_i && pwr_ctl_o.osc_en ##1 reader_en_i |=>
      pwr_ctl_o.clk_sel_xtal;
  endproperty
  a_settle: assert property (p_settle)
    else $error("clock output not switched after settling");
  property p_tmo;
    tmo_c <= WAKE_TMO_CYC + 13'ha;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("unconfirmed wake start did not power down");
  property p_hold_rcv;
    hold_c <= HOLD_RCV_CYC + 13'h5;
  endproperty
  a_hold_rcv: assert property (p_hold_rcv)
    else $error("no full operation after leaving hold");
  property p_idle_rcv;
    idle_c <= IDLE_RCV_CYC + 13'h5;
  endproperty
  a_idle_rcv: assert property (p_idle_rcv)
    else $error("no full operation after leaving idle");
endmodule : rpm_power_ctrl_props

bind rpm_power_ctrl rpm_power_ctrl_props rpm_power_ctrl_props_i (
  .core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reader_en_i, .settle_done_i, .pwr_ctl_o, .pwr_mode_o, .full_ready_o);

`default_nettype wire

// ==== verif/rpm_mcu_model.sv ====
// Model of the controller and analog side around the power sequencer.
`default_nettype none

module rpm_mcu_model #(
  parameter int unsigned CONF_DLY   = 3000,
  parameter int unsigned SETTLE_DLY = 40
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire rpm_pkg::rpm_pwr_ctl_t pwr_ctl_i,
  input  wire logic                  en_req_i,
  input  wire logic                  wake_req_i,
  input  wire logic                  confirm_i,
  output logic                       reader_en_o,
  output logic                       wake_pin_o,
  output logic                       settle_done_o
);
  import rpm_pkg::*;

  logic [7:0]  st_cnt_q;  // Cycles since the oscillator started.
  logic [11:0] cf_cnt_q;  // Cycles since the clock output switched.
  logic        cf_q;      // Activate pin raised to confirm a wake start.

  // Supplies settle a while after start and drop at once when stopped.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !pwr_ctl_i.osc_en) begin
      st_cnt_q <= 8'h00;
    end else if (st_cnt_q != SETTLE_DLY[7:0]) begin
      st_cnt_q <= st_cnt_q + 8'h01;
    end
  end
  assign settle_done_o = (st_cnt_q == SETTLE_DLY[7:0]);

  // A slow controller wakes late, yet inside the confirmation span.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !confirm_i || !pwr_ctl_i.clk_sel_xtal) begin
      cf_cnt_q <= 12'h000;
    end else if (cf_cnt_q != CONF_DLY[11:0]) begin
      cf_cnt_q <= cf_cnt_q + 12'h001;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !confirm_i) begin
      cf_q <= 1'b0;
    end else if (cf_cnt_q == CONF_DLY[11:0]) begin
      cf_q <= 1'b1;
    end
  end
  assign reader_en_o = en_req_i | cf_q;
  assign wake_pin_o  = wake_req_i;
endmodule : rpm_mcu_model

`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench of the reader power mode sequencer.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rpm_pkg::*;

  logic        core_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [4:0]  reg_addr_i = 5'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        reader_tx_start_i = 1'b0;
  logic        tag_resp_i = 1'b0;
  logic        rx_busy_i = 1'b0;
  logic [2:0]  first_rf_input_lvl_i = 3'h0;
  logic [2:0]  second_rf_input_lvl_i = 3'h0;
  logic        en_req = 1'b0;
  logic        wake_req = 1'b0;
  logic        confirm = 1'b0;
  logic        reader_en_i, wake_pin_i, settle_done_i, aux_clk_o;
  logic        full_ready_o;
  logic [7:0]  reg_rdata_o, rx_filter_o, d;
  rpm_pwr_ctl_t pwr_ctl_o;
  rpm_mode_t   pwr_mode_o;
  int          fails = 0;
  int          n_checks = 0;
  int          n;

  always #12.5 core_clk_i = ~core_clk_i;

  rpm_power_ctrl rpm_power_ctrl_i (.core_clk_i, .reset_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reader_en_i,
    .wake_pin_i, .settle_done_i, .reader_tx_start_i, .tag_resp_i,
    .rx_busy_i, .first_rf_input_lvl_i, .second_rf_input_lvl_i, .pwr_ctl_o,
    .pwr_mode_o, .aux_clk_o, .full_ready_o, .rx_filter_o);
  rpm_mcu_model rpm_mcu_model_i (.core_clk_i, .reset_n_i,
    .pwr_ctl_i(pwr_ctl_o), .en_req_i(en_req), .wake_req_i(wake_req),
    .confirm_i(confirm), .reader_en_o(reader_en_i),
    .wake_pin_o(wake_pin_i), .settle_done_o(settle_done_i));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Lands at the falling edge after k rising edges, where outputs settle.
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : cyc

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    v = reg_rdata_o;
  endtask : rd

  task automatic t_reset();
    cyc(1);
    chk(pwr_ctl_o, 16'h0000);
    chk(rx_filter_o, RX_PRESET0);
    rd(OFS_CHIP_CTRL, d);
    chk(d, CHIP_CTRL_RST);
    rd(OFS_PROTOCOL, d);
    chk(d, PROTOCOL_RST);
  endtask : t_reset

  // Wake start left unconfirmed, then partial power down on the level.
  task automatic t_wake_tmo();
    logic a0;
    wake_req <= 1'b1;
    n = 0;
    while (pwr_ctl_o.clk_sel_xtal !== 1'b1 && n < 3000) begin
      cyc(0);
      n++;
    end
    chk({pwr_ctl_o.reg_en, pwr_ctl_o.osc_en, n < 3000}, 3'h7);
    n = 0;
    while (pwr_ctl_o.osc_en !== 1'b0 && n < 5000) begin
      cyc(0);
      n++;
    end
    chk(n >= 3995 && n <= 4005, 16'h0001);
    cyc(4);
    chk(pwr_mode_o, RPM_MODE_PARTIAL);
    a0 = aux_clk_o;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (aux_clk_o === a0 && n < 1000) begin
        cyc(0);
        n++;
      end
      a0 = aux_clk_o;
    end
    chk(n, 16'(AUX_HALF_CYC));
    wake_req <= 1'b0;
    cyc(4);
    chk({pwr_mode_o, pwr_ctl_o}, 16'h0000);
  endtask : t_wake_tmo

  // Wake start confirmed late by the controller keeps the reader up.
  task automatic t_wake_conf();
    confirm <= 1'b1;
    wake_req <= 1'b1;
    cyc(4600);
    chk({reader_en_i, pwr_ctl_o.osc_en, pwr_ctl_o.clk_sel_xtal}, 3'h7);
    chk(pwr_mode_o, RPM_MODE_IDLE);
    en_req <= 1'b1;
    confirm <= 1'b0;
    wake_req <= 1'b0;
    cyc(4);
  endtask : t_wake_conf

  // Every mode code of the active state, with recovery spans out of hold and idle.
  task automatic t_modes();
    logic [7:0] wd [7] = '{8'h80, 8'h20, 8'h00, 8'h02, 8'h30, 8'ha2, 8'h22};
    logic [2:0] md [7] = '{3'h2, 3'h6, 3'h3, 3'h4, 3'h5, 3'h2, 3'h6};
    logic [3:0] cb [7] = '{4'h8, 4'h6, 4'h0, 4'h4, 4'h7, 4'h8, 4'h6};
    int lim [7] = '{0, 4005, 0, 1005, 1005, 0, 4005};
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CHIP_CTRL, wd[i]);
      cyc(1);
      chk(pwr_mode_o, md[i]);
      chk({pwr_ctl_o.reg_lowpwr, pwr_ctl_o.rx_en, pwr_ctl_o.tx_en,
           pwr_ctl_o.tx_half}, cb[i]);
      if (lim[i] > 0) begin
        n = 0;
        while (full_ready_o !== 1'b1 && n < 5000) begin
          cyc(0);
          n++;
        end
        chk(n <= lim[i], 16'h0001);
      end
    end
    rd(OFS_CHIP_CTRL, d);
    chk(d, 8'h22);
  endtask : t_modes

  // Peak strength per receiver, input swap, clear on transmission.
  task automatic t_rssi();
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CHIP_CTRL, {4'h2, s[0], 3'h2});
      cyc(1);
      chk(pwr_ctl_o.input_swap, s[0]);
      for (int p = 0; p < 2; p++) begin
        reader_tx_start_i <= 1'b1;
        @(posedge core_clk_i);
        reader_tx_start_i <= 1'b0;
        tag_resp_i <= (p == 0);
        rx_busy_i <= (p == 0);
        first_rf_input_lvl_i <= 3'h5;
        second_rf_input_lvl_i <= 3'h2;
        repeat (3) @(posedge core_clk_i);
        first_rf_input_lvl_i <= 3'h1;
        second_rf_input_lvl_i <= 3'h1;
        repeat (3) @(posedge core_clk_i);
        tag_resp_i <= 1'b0;
        rx_busy_i <= 1'b0;
        rd(OFS_RSSI, d);
        chk(d, p ? 8'h40 : (s ? 8'h6a : 8'h55));
      end
    end
  endtask : t_rssi

  // Protocol writes load filter presets; software may refine them.
  task automatic t_proto();
    logic [7:0] pre [4] = '{RX_PRESET0, RX_PRESET1, RX_PRESET2, RX_PRESET3};
    logic [7:0] e;
    for (int g = 3; g >= 0; g--) begin
      wr(OFS_PROTOCOL, {3'h0, g[1:0], 3'h0});
      cyc(1);
      chk(rx_filter_o, pre[g]);
      wr(OFS_RX_SPEC, 8'h5c);
      cyc(1);
      chk(rx_filter_o, 8'h5c);
    end
    rd(5'h1f, d);
    chk(d, 8'h00);
    rd(OFS_RSSI, d);
    wr(OFS_RSSI, ~d);
    rd(OFS_RSSI, e);
    chk(e, 8'h40);
    en_req <= 1'b0;
    cyc(4);
    chk({pwr_mode_o, pwr_ctl_o}, 16'h0001);
  endtask : t_proto

  initial begin
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_wake_tmo();
    t_wake_conf();
    t_modes();
    t_rssi();
    t_proto();
    summarize();
  end

  // Cuts a hang short; the whole run needs some 20000 cycles.
  initial begin
    repeat (60000) @(posedge core_clk_i);
    fails++;
    summarize();
  end
endmodule : tb

`default_nettype wire
